//--- core/slc_pkg.sv
`default_nettype none
package slc_pkg;
   // command codes of the limit bank
   localparam logic [7:0] CMD_FIRST = 8'h45;
   localparam logic [7:0] CMD_OUT_UV_ACT = 8'h45;
   localparam logic [7:0] CMD_OC_FLT_LIM = 8'h46;
   localparam logic [7:0] CMD_OC_FLT_ACT = 8'h47;
   localparam logic [7:0] CMD_OC_WRN_LIM = 8'h4A;
   localparam logic [7:0] CMD_RC_FLT_LIM = 8'h4B;
   localparam logic [7:0] CMD_RC_FLT_ACT = 8'h4C;
   localparam logic [7:0] CMD_OT_FLT_LIM = 8'h4F;
   localparam logic [7:0] CMD_OT_FLT_ACT = 8'h50;
   localparam logic [7:0] CMD_OT_WRN_LIM = 8'h51;
   localparam logic [7:0] CMD_UT_WRN_LIM = 8'h52;
   localparam logic [7:0] CMD_UT_FLT_LIM = 8'h53;
   localparam logic [7:0] CMD_UT_FLT_ACT = 8'h54;
   localparam logic [7:0] CMD_IN_OV_FLT_LIM = 8'h55;
   localparam logic [7:0] CMD_IN_OV_FLT_ACT = 8'h56;
   localparam logic [7:0] CMD_IN_OV_WRN_LIM = 8'h57;
   localparam logic [7:0] CMD_IN_UV_WRN_LIM = 8'h58;
   localparam logic [7:0] CMD_IN_UV_FLT_LIM = 8'h59;
   localparam logic [7:0] CMD_IN_UV_FLT_ACT = 8'h5A;
   localparam logic [7:0] CMD_GOOD_ON = 8'h5E;
   localparam logic [7:0] CMD_GOOD_OFF = 8'h5F;
   localparam logic [7:0] CMD_TON_DELAY = 8'h60;
   localparam int NUM_SLOTS = 28;
   localparam int NUM_CHAN = 4;

   // reset values
   localparam logic [15:0] RST_OUT_UV_ACT = 16'h007F;
   localparam logic [15:0] RST_OC_FLT_LIM = 16'hD280;
   localparam logic [15:0] RST_OC_FLT_ACT = 16'h0000;
   localparam logic [15:0] RST_OC_WRN_LIM = 16'hCA80;
   localparam logic [15:0] RST_RC_FLT_LIM = 16'hB400;
   localparam logic [15:0] RST_RC_FLT_ACT = 16'h0000;
   localparam logic [15:0] RST_OT_FLT_LIM = 16'hEA08;
   localparam logic [15:0] RST_OT_FLT_ACT = 16'h00B8;
   localparam logic [15:0] RST_OT_WRN_LIM = 16'hE3C0;
   localparam logic [15:0] RST_UT_WRN_LIM = 16'h8000;
   localparam logic [15:0] RST_UT_FLT_LIM = 16'hCD80;
   localparam logic [15:0] RST_UT_FLT_ACT = 16'h00B8;
   localparam logic [15:0] RST_IN_OV_FLT_LIM = 16'hD3C0;
   localparam logic [15:0] RST_IN_OV_FLT_ACT = 16'h0080;
   localparam logic [15:0] RST_IN_OV_WRN_LIM = 16'hD380;
   localparam logic [15:0] RST_IN_UV_WRN_LIM = 16'h8000;
   localparam logic [15:0] RST_IN_UV_FLT_LIM = 16'h8000;
   localparam logic [15:0] RST_IN_UV_FLT_ACT = 16'h0000;
   localparam logic [15:0] RST_GOOD_ON = 16'h1EB8;
   localparam logic [15:0] RST_GOOD_OFF = 16'h1E14;
   localparam logic [15:0] RST_TON_DELAY = 16'hBA00;

   // number formats: output voltage words carry a fixed exponent of -13
   localparam int VOUT_EXPONENT = -13;
   localparam int FIX_FRAC = 16;
   localparam int FIX_W = 48;
   localparam logic [15:0] BYTE_MASK = 16'h00FF;

   // timing: turn-on delay is programmed in milliseconds
   localparam int CLK_PERIOD_NS = 40;
   localparam int NS_PER_MS = 1000000;
   localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;

   // per-channel telemetry sample
   typedef struct packed {
      logic [15:0] vout;
      logic [15:0] iout;
      logic [15:0] temp;
   } slc_telem_t;

   // per-channel limit flags
   typedef struct packed {
      logic oc_fault;
      logic oc_warn;
      logic rc_fault;
      logic ot_fault;
      logic ot_warn;
      logic ut_warn;
      logic ut_fault;
   } slc_chan_flags_t;

   // input supply limit flags
   typedef struct packed {
      logic ov_fault;
      logic ov_warn;
      logic uv_warn;
      logic uv_fault;
   } slc_in_flags_t;
endpackage
`default_nettype wire

//--- core/slc_limit_bank.sv
`timescale 1ns/10ps
`default_nettype none
module slc_limit_bank #(
   parameter int CYCLES_PER_MS = slc_pkg::CYCLES_PER_MS
) (
   // clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESET_IN,
   // command access
   input wire logic [7:0] CMD_CODE_IN,
   input wire logic CMD_WRITE_IN,
   input wire logic [15:0] CMD_WDATA_IN,
   input wire logic [7:0] PAGE_IN,
   output logic [15:0] CMD_RDATA_OUT,
   output logic CMD_HIT_OUT,
   // telemetry samples
   input wire logic [3:0] TELEM_VALID_IN,
   input wire slc_pkg::slc_telem_t [3:0] TELEM_IN,
   input wire logic VIN_VALID_IN,
   input wire logic [15:0] INPUT_SENSE_PIN_IN,
   // channel control
   input wire logic [3:0] CHANNEL_ON_IN,
   input wire logic [3:0] OUT_UV_FAULT_IN,
   input wire logic GOOD_OFF_USES_UNDERVOLT_BIT_IN,
   // channel results
   output logic [3:0] CHANNEL_ENABLE_OUTPUT_OUT,
   output logic [3:0] POWER_GOOD_OUT,
   output slc_pkg::slc_chan_flags_t [3:0] CHAN_FLAGS_OUT,
   output logic [3:0] FAULT_STROBE_OUT,
   output logic [3:0][7:0] FAULT_ACTION_OUT,
   // input supply results
   output slc_pkg::slc_in_flags_t INPUT_FLAGS_OUT,
   output logic INPUT_FAULT_STROBE_OUT,
   output logic [7:0] INPUT_FAULT_ACTION_OUT
);

   // slot index of a command inside the storage arrays
   function automatic logic [4:0] slot(input logic [7:0] code);
      logic [7:0] d;
      d = code - slc_pkg::CMD_FIRST;
      return d[4:0];
   endfunction

   // which codes exist, which are paged, which are byte wide
   function automatic logic [2:0] code_kind(input logic [7:0] code);
      // {mapped, paged, byte}
      case (code)
         slc_pkg::CMD_OUT_UV_ACT, slc_pkg::CMD_OC_FLT_ACT, slc_pkg::CMD_RC_FLT_ACT,
         slc_pkg::CMD_OT_FLT_ACT, slc_pkg::CMD_UT_FLT_ACT: return 3'h7;
         slc_pkg::CMD_OC_FLT_LIM, slc_pkg::CMD_OC_WRN_LIM, slc_pkg::CMD_RC_FLT_LIM,
         slc_pkg::CMD_OT_FLT_LIM, slc_pkg::CMD_OT_WRN_LIM, slc_pkg::CMD_UT_WRN_LIM,
         slc_pkg::CMD_UT_FLT_LIM, slc_pkg::CMD_GOOD_ON, slc_pkg::CMD_GOOD_OFF,
         slc_pkg::CMD_TON_DELAY: return 3'h6;
         slc_pkg::CMD_IN_OV_FLT_ACT, slc_pkg::CMD_IN_UV_FLT_ACT: return 3'h5;
         slc_pkg::CMD_IN_OV_FLT_LIM, slc_pkg::CMD_IN_OV_WRN_LIM, slc_pkg::CMD_IN_UV_WRN_LIM,
         slc_pkg::CMD_IN_UV_FLT_LIM: return 3'h4;
         default: return 3'h0;
      endcase
   endfunction

   // reset value of each setting
   function automatic logic [15:0] rst_val(input logic [7:0] code);
      case (code)
         slc_pkg::CMD_OUT_UV_ACT: return slc_pkg::RST_OUT_UV_ACT;
         slc_pkg::CMD_OC_FLT_LIM: return slc_pkg::RST_OC_FLT_LIM;
         slc_pkg::CMD_OC_FLT_ACT: return slc_pkg::RST_OC_FLT_ACT;
         slc_pkg::CMD_OC_WRN_LIM: return slc_pkg::RST_OC_WRN_LIM;
         slc_pkg::CMD_RC_FLT_LIM: return slc_pkg::RST_RC_FLT_LIM;
         slc_pkg::CMD_RC_FLT_ACT: return slc_pkg::RST_RC_FLT_ACT;
         slc_pkg::CMD_OT_FLT_LIM: return slc_pkg::RST_OT_FLT_LIM;
         slc_pkg::CMD_OT_FLT_ACT: return slc_pkg::RST_OT_FLT_ACT;
         slc_pkg::CMD_OT_WRN_LIM: return slc_pkg::RST_OT_WRN_LIM;
         slc_pkg::CMD_UT_WRN_LIM: return slc_pkg::RST_UT_WRN_LIM;
         slc_pkg::CMD_UT_FLT_LIM: return slc_pkg::RST_UT_FLT_LIM;
         slc_pkg::CMD_UT_FLT_ACT: return slc_pkg::RST_UT_FLT_ACT;
         slc_pkg::CMD_IN_OV_FLT_LIM: return slc_pkg::RST_IN_OV_FLT_LIM;
         slc_pkg::CMD_IN_OV_FLT_ACT: return slc_pkg::RST_IN_OV_FLT_ACT;
         slc_pkg::CMD_IN_OV_WRN_LIM: return slc_pkg::RST_IN_OV_WRN_LIM;
         slc_pkg::CMD_IN_UV_WRN_LIM: return slc_pkg::RST_IN_UV_WRN_LIM;
         slc_pkg::CMD_IN_UV_FLT_LIM: return slc_pkg::RST_IN_UV_FLT_LIM;
         slc_pkg::CMD_IN_UV_FLT_ACT: return slc_pkg::RST_IN_UV_FLT_ACT;
         slc_pkg::CMD_GOOD_ON: return slc_pkg::RST_GOOD_ON;
         slc_pkg::CMD_GOOD_OFF: return slc_pkg::RST_GOOD_OFF;
         slc_pkg::CMD_TON_DELAY: return slc_pkg::RST_TON_DELAY;
         default: return 16'h0000;
      endcase
   endfunction

   // linear-11 word to signed fixed point with 16 fraction bits
   function automatic logic signed [47:0] l11_fix(input logic [15:0] w);
      logic signed [47:0] m;
      logic signed [5:0] e;
      logic signed [5:0] sh;
      m = {{37{w[10]}}, w[10:0]};
      e = {w[15], w[15:11]};
      sh = e + 6'sh10;
      return m <<< sh[4:0];
   endfunction

   // setting storage, one copy per channel for paged codes
   logic [15:0] paged_reg [slc_pkg::NUM_CHAN][slc_pkg::NUM_SLOTS];
   logic [15:0] unpaged_reg [slc_pkg::NUM_SLOTS];
   logic [15:0] rdata_reg;
   logic hit_reg;

   // command decode; a page beyond the last channel makes paged codes miss
   wire logic [2:0] kind = code_kind(CMD_CODE_IN);
   wire logic [4:0] cmd_slot = slot(CMD_CODE_IN);
   wire logic page_ok = (PAGE_IN < 8'(slc_pkg::NUM_CHAN));
   wire logic [1:0] page_ch = PAGE_IN[1:0];
   wire logic cmd_hit = kind[2] & (~kind[1] | page_ok);
   wire logic [15:0] wr_val = kind[0] ? (CMD_WDATA_IN & slc_pkg::BYTE_MASK) : CMD_WDATA_IN;
   wire logic [15:0] rd_sel = kind[1] ? paged_reg[page_ch][cmd_slot] : unpaged_reg[cmd_slot];
   wire logic [15:0] rdata_next = cmd_hit ? rd_sel : 16'h0000;

   // settings may be written at any time; reset restores documented values
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         for (int s = 0; s < slc_pkg::NUM_SLOTS; s++) begin
            unpaged_reg[s] <= rst_val(8'(s) + slc_pkg::CMD_FIRST);
            for (int c = 0; c < slc_pkg::NUM_CHAN; c++) begin
               paged_reg[c][s] <= rst_val(8'(s) + slc_pkg::CMD_FIRST);
            end
         end
      end else if (CMD_WRITE_IN && cmd_hit) begin
         if (kind[1]) begin
            paged_reg[page_ch][cmd_slot] <= wr_val;
         end else begin
            unpaged_reg[cmd_slot] <= wr_val;
         end
      end
   end

   // read data registered one cycle after the code is presented
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         rdata_reg <= 16'h0000;
         hit_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         hit_reg <= cmd_hit;
      end
   end
   assign CMD_RDATA_OUT = rdata_reg;
   assign CMD_HIT_OUT = hit_reg;

   // input supply limits are shared by all channels
   wire logic signed [47:0] vin_fix = l11_fix(INPUT_SENSE_PIN_IN);
   wire slc_pkg::slc_in_flags_t in_flags_next = '{
      ov_fault: vin_fix > l11_fix(unpaged_reg[slot(slc_pkg::CMD_IN_OV_FLT_LIM)]),
      ov_warn: vin_fix > l11_fix(unpaged_reg[slot(slc_pkg::CMD_IN_OV_WRN_LIM)]),
      uv_warn: vin_fix < l11_fix(unpaged_reg[slot(slc_pkg::CMD_IN_UV_WRN_LIM)]),
      uv_fault: vin_fix < l11_fix(unpaged_reg[slot(slc_pkg::CMD_IN_UV_FLT_LIM)])
   };
   slc_pkg::slc_in_flags_t in_flags_reg;
   logic in_strobe_reg;
   logic [7:0] in_action_reg;
   wire logic in_ov_rise = VIN_VALID_IN & in_flags_next.ov_fault & ~in_flags_reg.ov_fault;
   wire logic in_uv_rise = VIN_VALID_IN & in_flags_next.uv_fault & ~in_flags_reg.uv_fault;
   // overvoltage takes precedence when both appear on one sample
   wire logic [7:0] in_action_next = in_ov_rise ?
      unpaged_reg[slot(slc_pkg::CMD_IN_OV_FLT_ACT)][7:0] :
      unpaged_reg[slot(slc_pkg::CMD_IN_UV_FLT_ACT)][7:0];

   // flags follow the latest input sample; strobe marks a newly raised fault
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         in_flags_reg <= '0;
         in_strobe_reg <= 1'b0;
         in_action_reg <= 8'h00;
      end else begin
         if (VIN_VALID_IN) begin
            in_flags_reg <= in_flags_next;
         end
         in_strobe_reg <= in_ov_rise | in_uv_rise;
         if (in_ov_rise | in_uv_rise) begin
            in_action_reg <= in_action_next;
         end
      end
   end
   assign INPUT_FLAGS_OUT = in_flags_reg;
   assign INPUT_FAULT_STROBE_OUT = in_strobe_reg;
   assign INPUT_FAULT_ACTION_OUT = in_action_reg;

   // per-channel supervision
   for (genvar ch = 0; ch < slc_pkg::NUM_CHAN; ch++) begin : g_chan
      wire slc_pkg::slc_telem_t t = TELEM_IN[ch];
      wire logic signed [47:0] i_fix = l11_fix(t.iout);
      wire logic signed [47:0] t_fix = l11_fix(t.temp);
      wire slc_pkg::slc_chan_flags_t flags_next = '{
         oc_fault: i_fix > l11_fix(paged_reg[ch][slot(slc_pkg::CMD_OC_FLT_LIM)]),
         oc_warn: i_fix > l11_fix(paged_reg[ch][slot(slc_pkg::CMD_OC_WRN_LIM)]),
         rc_fault: i_fix < l11_fix(paged_reg[ch][slot(slc_pkg::CMD_RC_FLT_LIM)]),
         ot_fault: t_fix > l11_fix(paged_reg[ch][slot(slc_pkg::CMD_OT_FLT_LIM)]),
         ot_warn: t_fix > l11_fix(paged_reg[ch][slot(slc_pkg::CMD_OT_WRN_LIM)]),
         ut_warn: t_fix < l11_fix(paged_reg[ch][slot(slc_pkg::CMD_UT_WRN_LIM)]),
         ut_fault: t_fix < l11_fix(paged_reg[ch][slot(slc_pkg::CMD_UT_FLT_LIM)])
      };
      slc_pkg::slc_chan_flags_t flags_reg;
      logic uv_prev_reg;
      logic strobe_reg;
      logic [7:0] action_reg;
      logic good_reg;
      logic enable_reg;
      logic [31:0] count_reg;

      // new faults on this sample; uv comes from the outside comparator
      wire logic v = TELEM_VALID_IN[ch];
      wire logic oc_rise = v & flags_next.oc_fault & ~flags_reg.oc_fault;
      wire logic rc_rise = v & flags_next.rc_fault & ~flags_reg.rc_fault;
      wire logic ot_rise = v & flags_next.ot_fault & ~flags_reg.ot_fault;
      wire logic ut_rise = v & flags_next.ut_fault & ~flags_reg.ut_fault;
      wire logic uv_rise = OUT_UV_FAULT_IN[ch] & ~uv_prev_reg;
      wire logic any_rise = oc_rise | rc_rise | ot_rise | ut_rise | uv_rise;
      // one action per cycle: current faults outrank temperature and voltage
      wire logic [7:0] action_next =
         oc_rise ? paged_reg[ch][slot(slc_pkg::CMD_OC_FLT_ACT)][7:0] :
         rc_rise ? paged_reg[ch][slot(slc_pkg::CMD_RC_FLT_ACT)][7:0] :
         ot_rise ? paged_reg[ch][slot(slc_pkg::CMD_OT_FLT_ACT)][7:0] :
         ut_rise ? paged_reg[ch][slot(slc_pkg::CMD_UT_FLT_ACT)][7:0] :
         paged_reg[ch][slot(slc_pkg::CMD_OUT_UV_ACT)][7:0];

      // output voltage words are unsigned mantissas sharing one exponent
      wire logic [15:0] vout = t.vout;
      wire logic good_on_hit = v & (vout >= paged_reg[ch][slot(slc_pkg::CMD_GOOD_ON)]);
      wire logic good_off_hit = GOOD_OFF_USES_UNDERVOLT_BIT_IN ? OUT_UV_FAULT_IN[ch] :
         v & (vout <= paged_reg[ch][slot(slc_pkg::CMD_GOOD_OFF)]);
      wire logic good_next = good_on_hit | (good_reg & ~good_off_hit);

      // turn-on delay in cycles; negative delays count as zero
      wire logic signed [47:0] dly_fix = l11_fix(paged_reg[ch][slot(slc_pkg::CMD_TON_DELAY)]);
      wire logic signed [80:0] dly_prod = dly_fix * $signed({1'b0, 32'(CYCLES_PER_MS)});
      wire logic [31:0] dly_cycles = dly_fix[47] ? 32'h0000_0000 : dly_prod[47:16];
      wire logic dly_done = (count_reg >= dly_cycles);
      wire logic enable_next = CHANNEL_ON_IN[ch] & (enable_reg | dly_done);
      wire logic [31:0] count_next = (CHANNEL_ON_IN[ch] & ~enable_next) ? count_reg + 32'h0000_0001 : 32'h0000_0000;

      // flags, fault action and power good for this channel
      always_ff @(posedge SYS_CLK_IN) begin
         if (RESET_IN) begin
            flags_reg <= '0;
            uv_prev_reg <= 1'b0;
            strobe_reg <= 1'b0;
            action_reg <= 8'h00;
            good_reg <= 1'b0;
         end else begin
            if (v) begin
               flags_reg <= flags_next;
            end
            uv_prev_reg <= OUT_UV_FAULT_IN[ch];
            strobe_reg <= any_rise;
            if (any_rise) begin
               action_reg <= action_next;
            end
            good_reg <= good_next;
         end
      end

      // enable waits out the delay; dropping the request turns it off at once
      always_ff @(posedge SYS_CLK_IN) begin
         if (RESET_IN) begin
            enable_reg <= 1'b0;
            count_reg <= 32'h0000_0000;
         end else begin
            enable_reg <= enable_next;
            count_reg <= count_next;
         end
      end

      assign CHAN_FLAGS_OUT[ch] = flags_reg;
      assign FAULT_STROBE_OUT[ch] = strobe_reg;
      assign FAULT_ACTION_OUT[ch] = action_reg;
      assign POWER_GOOD_OUT[ch] = good_reg;
      assign CHANNEL_ENABLE_OUTPUT_OUT[ch] = enable_reg;
   end

endmodule
`default_nettype wire

//--- bench/slc_limit_bank_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module slc_limit_bank_checker (
   // clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESET_IN,
   // command port
   input wire logic [7:0] CMD_CODE_IN,
   input wire logic [7:0] PAGE_IN,
   input wire logic [15:0] CMD_RDATA_OUT,
   input wire logic CMD_HIT_OUT,
   // channel side, all four channels; the checks use channel 0 only
   input wire logic [3:0] TELEM_VALID_IN,
   input wire logic [3:0] CHANNEL_ON_IN,
   input wire logic [3:0] OUT_UV_FAULT_IN,
   input wire logic [3:0] CHANNEL_ENABLE_OUTPUT_OUT,
   input wire logic [3:0] POWER_GOOD_OUT,
   input wire slc_pkg::slc_chan_flags_t [3:0] CHAN_FLAGS_OUT,
   input wire logic [3:0] FAULT_STROBE_OUT,
   input wire logic [3:0][7:0] FAULT_ACTION_OUT
);
   default clocking @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (RESET_IN);
   // code classes; holes such as 0x48 sit in the paged span but miss anyway
   wire logic paged_code = CMD_CODE_IN inside {[8'h45:8'h54], [8'h5E:8'h60]};
   wire logic input_code = CMD_CODE_IN inside {[8'h55:8'h5A]};
   wire logic byte_code = CMD_CODE_IN inside {8'h45, 8'h47, 8'h4C, 8'h50, 8'h54, 8'h56, 8'h5A};
   a_miss_reads_zero: assert property (!CMD_HIT_OUT |-> CMD_RDATA_OUT == 16'h0000)
      else $error("read data not zero on a miss");
   a_bad_page_miss: assert property (paged_code && PAGE_IN >= 8'h04 |=> !CMD_HIT_OUT)
      else $error("paged code hit with bad page");
   a_input_code_hit: assert property (!$past(RESET_IN) && input_code |=> CMD_HIT_OUT)
      else $error("input limit code missed");
   a_byte_upper_zero: assert property (byte_code |=> CMD_RDATA_OUT[15:8] == 8'h00)
      else $error("byte setting upper half not zero");
   a_strobe_one_cycle: assert property (FAULT_STROBE_OUT[0] && !TELEM_VALID_IN[0] &&
      $stable(OUT_UV_FAULT_IN[0]) |=> !FAULT_STROBE_OUT[0])
      else $error("fault strobe longer than one cycle");
   a_strobe_has_cause: assert property (FAULT_STROBE_OUT[0] |->
      $past(TELEM_VALID_IN[0]) || $past(OUT_UV_FAULT_IN[0]))
      else $error("fault strobe without sample");
   a_flags_hold: assert property (!TELEM_VALID_IN[0] |=> $stable(CHAN_FLAGS_OUT[0]))
      else $error("flags moved without sample");
   a_action_held: assert property (!FAULT_STROBE_OUT[0] |-> $stable(FAULT_ACTION_OUT[0]))
      else $error("action byte moved without strobe");
   a_enable_off: assert property (!CHANNEL_ON_IN[0] |=> !CHANNEL_ENABLE_OUTPUT_OUT[0])
      else $error("enable high while channel off");
   a_enable_cause: assert property ($rose(CHANNEL_ENABLE_OUTPUT_OUT[0]) |-> $past(CHANNEL_ON_IN[0]))
      else $error("enable rose without on request");
   a_good_on_sample: assert property ($rose(POWER_GOOD_OUT[0]) |-> $past(TELEM_VALID_IN[0]))
      else $error("power good rose without sample");
endmodule
bind slc_limit_bank slc_limit_bank_checker u_checker (
   .SYS_CLK_IN, .RESET_IN, .CMD_CODE_IN, .PAGE_IN, .CMD_RDATA_OUT, .CMD_HIT_OUT, .TELEM_VALID_IN,
   .CHANNEL_ON_IN, .OUT_UV_FAULT_IN, .CHANNEL_ENABLE_OUTPUT_OUT, .POWER_GOOD_OUT, .CHAN_FLAGS_OUT,
   .FAULT_STROBE_OUT, .FAULT_ACTION_OUT);
`default_nettype wire

//--- bench/slc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module slc_host_model (
   // clock
   input wire logic clk_in,
   // command requests
   output logic [7:0] code_out,
   output logic write_out,
   output logic [15:0] wdata_out,
   output logic [7:0] page_out,
   // answers
   input wire logic [15:0] rdata_in,
   input wire logic hit_in
);
   // idle lines at time zero
   initial begin
      code_out = 8'h00;
      write_out = 1'b0;
      wdata_out = 16'h0000;
      page_out = 8'h00;
   end
   // one-cycle write; data shows the inverse once released so stale words never look valid
   task automatic write_cmd(input logic [7:0] code, input logic [7:0] page, input logic [15:0] data);
      @(negedge clk_in);
      code_out = code;
      page_out = page;
      wdata_out = data;
      write_out = 1'b1;
      @(negedge clk_in);
      write_out = 1'b0;
      wdata_out = ~data;
   endtask
   // answer is registered, so it is taken one edge after the code goes out
   task automatic read_cmd(input logic [7:0] code, input logic [7:0] page, output logic [15:0] data,
      output logic hit);
      @(negedge clk_in);
      code_out = code;
      page_out = page;
      @(negedge clk_in);
      data = rdata_in;
      hit = hit_in;
   endtask
endmodule
`default_nettype wire

//--- bench/supervisor_limit_commands_tb.sv
`timescale 1ns/10ps
`default_nettype none
module supervisor_limit_commands_tb;
   localparam int CPM = 10;
   // settings and their reset words
   localparam logic [7:0] codes [21] = '{8'h45, 8'h46, 8'h47, 8'h4A, 8'h4B, 8'h4C, 8'h4F, 8'h50, 8'h51, 8'h52,
      8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h5E, 8'h5F, 8'h60};
   localparam logic [15:0] rst_words [21] = '{16'h007F, 16'hD280, 16'h0000, 16'hCA80, 16'hB400, 16'h0000,
      16'hEA08, 16'h00B8, 16'hE3C0, 16'h8000, 16'hCD80, 16'h00B8, 16'hD3C0, 16'h0080, 16'hD380, 16'h8000,
      16'h8000, 16'h0000, 16'h1EB8, 16'h1E14, 16'hBA00};
   // channel 0 samples: vout, iout, temp, flags, strobe, good
   localparam logic [15:0] rows [5][6] = '{
      '{16'h1EB8, 16'hD2A0, 16'hE320, 16'h0060, 16'h0001, 16'h0001},
      '{16'h1E15, 16'hD180, 16'hE320, 16'h0020, 16'h0000, 16'h0001},
      '{16'h1E14, 16'hCA80, 16'hEA10, 16'h000C, 16'h0001, 16'h0000},
      '{16'h1E14, 16'hBC00, 16'hCD00, 16'h0013, 16'h0001, 16'h0000},
      '{16'h1EB8, 16'hD180, 16'hE320, 16'h0020, 16'h0000, 16'h0001}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] code, page;
   logic wr, hit, istrobe;
   logic [15:0] wdata, rdata;
   logic [3:0] tvalid = 4'h0;
   slc_pkg::slc_telem_t [3:0] telem = '0;
   logic vvalid = 1'b0;
   logic [15:0] vin = 16'h0000;
   logic [3:0] chan_on = 4'h0;
   logic [3:0] uvf = 4'h0;
   logic gbit = 1'b0;
   logic [3:0] en, good, strobe;
   slc_pkg::slc_chan_flags_t [3:0] flags;
   logic [3:0][7:0] act;
   slc_pkg::slc_in_flags_t iflags;
   logic [7:0] iact;
   int errors = 0;
   int tests_run = 0;
   int seed = 3279;
   always #20 clk = ~clk;
   slc_limit_bank #(.CYCLES_PER_MS(CPM)) dut (
      .SYS_CLK_IN(clk), .RESET_IN(rst), .CMD_CODE_IN(code), .CMD_WRITE_IN(wr), .CMD_WDATA_IN(wdata),
      .PAGE_IN(page), .CMD_RDATA_OUT(rdata), .CMD_HIT_OUT(hit), .TELEM_VALID_IN(tvalid), .TELEM_IN(telem),
      .VIN_VALID_IN(vvalid), .INPUT_SENSE_PIN_IN(vin), .CHANNEL_ON_IN(chan_on), .OUT_UV_FAULT_IN(uvf),
      .GOOD_OFF_USES_UNDERVOLT_BIT_IN(gbit), .CHANNEL_ENABLE_OUTPUT_OUT(en), .POWER_GOOD_OUT(good),
      .CHAN_FLAGS_OUT(flags), .FAULT_STROBE_OUT(strobe), .FAULT_ACTION_OUT(act), .INPUT_FLAGS_OUT(iflags),
      .INPUT_FAULT_STROBE_OUT(istrobe), .INPUT_FAULT_ACTION_OUT(iact));
   slc_host_model u_host (.clk_in(clk), .code_out(code), .write_out(wr), .wdata_out(wdata), .page_out(page),
      .rdata_in(rdata), .hit_in(hit));
   // compare and count
   task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic final_report();
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // byte settings keep only their low byte
   function automatic logic [15:0] stored(input logic [7:0] c, input logic [15:0] d);
      return (c inside {8'h45, 8'h47, 8'h4C, 8'h50, 8'h54, 8'h56, 8'h5A}) ? (d & 16'h00FF) : d;
   endfunction
   // delay in cycles from a millisecond word; negative delays clamp to zero
   function automatic int ton_cycles(input logic [15:0] w);
      int m, e, v;
      m = $signed(w[10:0]);
      e = $signed(w[15:11]);
      v = (e >= 0) ? (m * CPM) <<< e : (m * CPM) >>> (-e);
      return (v < 0) ? 0 : v;
   endfunction
   // one-cycle sample pulse, channel 0 or the input sense
   task automatic sample(input logic inp, input logic [15:0] v, input logic [15:0] i, input logic [15:0] t);
      @(negedge clk);
      vin = v;
      telem[0] = '{v, i, t};
      vvalid = inp;
      tvalid = {3'b000, ~inp};
      @(negedge clk);
      vvalid = 1'b0;
      tvalid = 4'h0;
   endtask
   initial begin
      logic [15:0] d, v, a;
      logic [15:0] xa [5];
      logic [15:0] iw [6];
      logic h;
      int n;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      // reset word, page 3 storage, then page 0 untouched unless the setting is shared
      for (int k = 0; k < 21; k++) begin
         u_host.read_cmd(codes[k], 8'h00, d, h);
         chk({h, d}, {1'b1, rst_words[k]}, "reset word");
         v = 16'($random(seed));
         if (codes[k] == 8'h4B)
            v = v | 16'h0400;
         u_host.write_cmd(codes[k], 8'h03, v);
         u_host.read_cmd(codes[k], 8'h03, d, h);
         chk({h, d}, {1'b1, stored(codes[k], v)}, "page 3 word");
         u_host.read_cmd(codes[k], 8'h00, d, h);
         chk({h, d}, {1'b1, (codes[k] inside {[8'h55:8'h5A]} ? stored(codes[k], v) : rst_words[k])},
            "page 0 word");
      end
      // bad page and unmapped code miss and store nothing
      u_host.write_cmd(8'h46, 8'h04, 16'h1234);
      for (int k = 0; k < 3; k++) begin
         u_host.read_cmd(k == 1 ? 8'h48 : 8'h46, k == 2 ? 8'h00 : 8'h04, d, h);
         chk({h, d}, (k == 2) ? {1'b1, 16'hD280} : 17'h00000, "refused access");
      end
      // channel 0 limits against fresh samples, priority picks the action
      a = {8'h00, 8'($random(seed))};
      u_host.write_cmd(8'h47, 8'h00, a);
      xa = '{a, a, 16'h00B8, 16'h0000, 16'h0000};
      for (int k = 0; k < 5; k++) begin
         sample(1'b0, rows[k][0], rows[k][1], rows[k][2]);
         chk({10'h000, flags[0]}, {1'b0, rows[k][3]}, "flags");
         chk({8'h00, strobe[0], act[0]}, {8'h00, rows[k][4][0], xa[k][7:0]}, "strobe");
         chk({16'h0000, good[0]}, {16'h0000, rows[k][5][0]}, "power good");
      end
      // channels that never saw a sample or an on request stay quiet
      chk({8'h00, strobe[3:1], good[3:1], en[3:1]}, 17'h00000, "idle channels");
      // undervoltage fault path and the uses-undervoltage bit
      @(negedge clk);
      uvf = 4'h1;
      gbit = 1'b1;
      @(negedge clk);
      chk({8'h00, strobe[0], act[0]}, {8'h00, 1'b1, 8'h7F}, "uv strobe");
      sample(1'b0, 16'h1E50, 16'hD180, 16'hE320);
      chk({16'h0000, good[0]}, 17'h00000, "good with uv");
      uvf = 4'h0;
      gbit = 1'b0;
      // turn-on delay at the default and at 2.0 ms
      for (int k = 0; k < 2; k++) begin
         v = k ? 16'hC200 : 16'hBA00;
         u_host.write_cmd(8'h60, 8'h00, v);
         chan_on = 4'h1;
         n = 0;
         while (en[0] !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
         end
         chk({1'b0, 16'(n)}, {1'b0, 16'(ton_cycles(v) + 1)}, "turn-on delay");
         if (n >= 200)
            final_report();
         chan_on = 4'h0;
      end
      // shared input limits written through page 2
      a = {8'h00, 8'($random(seed))};
      v = {8'h00, 8'($random(seed))};
      iw = '{16'hD3C0, a, 16'hD380, 16'hD240, 16'hD280, v};
      for (int k = 0; k < 6; k++)
         u_host.write_cmd(8'h55 + 8'(k), 8'h02, iw[k]);
      for (int k = 0; k < 2; k++) begin
         sample(1'b1, k ? 16'hCA80 : 16'hD3E0, 16'h0000, 16'h0000);
         chk({13'h0000, iflags}, k ? 17'h00003 : 17'h0000C, "input flags");
         // the action bytes sit at positions 1 (overvoltage) and 5 (undervoltage)
         chk({8'h00, istrobe, iact}, {8'h00, 1'b1, iw[k * 4 + 1][7:0]}, "input strobe");
      end
      final_report();
   end
   // a hang is cut short and counted
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      final_report();
   end
endmodule
`default_nettype wire
